// file: rtl/pfs_bank.v
// protector fault status bank with avalon-mm slave
// Summary of operation
// R1: six cell overvoltage flags, comparator-qualified
// R2: six undertemperature flags, comparator and function qualified
// R3: overtemperature flags forced while reference off
// R4: fault tone arrival sets received flag
// R5: two missed heartbeats set missing flag
// R6: too-frequent heartbeats set too-fast flag
// R7: software ignores too-fast while missing set
// R8: undertemperature flags forced while reference off
//
// Register access over Avalon-MM is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "pfs_defines.vh"

module pfs_bank (
  input wire i_clk, // 40 MHz core clock
  input wire i_rst_n, // sync reset, active low
  input wire [`PFS_ADDR_W-1:0] i_avs_address, // byte address
  input wire i_avs_read, // read request
  input wire i_avs_write, // write request
  input wire [31:0] i_avs_writedata, // write data
  input wire [3:0] i_avs_byteenable, // byte lanes
  output reg [31:0] o_avs_readdata, // read data, registered
  output wire o_avs_waitrequest, // stall
  input wire [5:0] i_cell_ov_raw, // cell overvoltage comparators
  input wire [5:0] i_cell_cmp_en, // cell comparator enables
  input wire [5:0] i_therm_ut_raw, // thermistor undertemperature comparators
  input wire [5:0] i_therm_ot_raw, // thermistor overtemperature comparators
  input wire [5:0] i_therm_cmp_en, // thermistor comparator enables
  input wire i_ut_func_en, // undertemperature protection enabled
  input wire i_thermistor_reference_output_en, // thermistor reference output enabled
  input wire i_fault_tone, // fault tone detected, pulse
  input wire i_hb_missed, // expected heartbeat slot passed empty, pulse
  input wire i_hb_seen, // heartbeat received, pulse
  input wire i_hb_early, // heartbeat arrived before minimum spacing, pulse
  output wire o_irq // level interrupt
);

  localparam ST_IDLE = 2'b01;
  localparam ST_ACK = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg fault_rec_ff;
  reg hb_miss_ff;
  reg heartbeat_too_fast_ff;
  reg miss_cnt_ff;
  wire [7:0] ov_flags;
  wire [7:0] ut_flags;
  wire [7:0] ot_flags;
  wire [7:0] tone_flags;
  wire ov_rise;
  wire ut_rise;
  wire ot_rise;
  wire [5:0] irq_status;
  wire [5:0] irq_enable;
  wire [5:0] events;
  wire [11:0] word_idx;
  wire req;
  wire wr_take;
  wire lane0;
  reg [31:0] rd_mux;

  // R1: overvoltage flags
  pfs_flag_reg u_ov (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_raw(i_cell_ov_raw),
    .i_valid(i_cell_cmp_en),
    .i_force(1'b0),
    .o_flags(ov_flags),
    .o_rise(ov_rise)
  );

  // R2: undertemperature qualify
  // R8: reference forces fault
  pfs_flag_reg u_ut (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_raw(i_therm_ut_raw),
    .i_valid(i_therm_cmp_en & {`PFS_CHAN_N{i_ut_func_en}}),
    .i_force(~i_thermistor_reference_output_en),
    .o_flags(ut_flags),
    .o_rise(ut_rise)
  );

  // R3: overtemperature with force
  pfs_flag_reg u_ot (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_raw(i_therm_ot_raw),
    .i_valid(i_therm_cmp_en),
    .i_force(~i_thermistor_reference_output_en),
    .o_flags(ot_flags),
    .o_rise(ot_rise)
  );

  // tone flags are sticky until reset; no clearing path exists for them here
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      fault_rec_ff <= 1'b0;
      hb_miss_ff <= 1'b0;
      heartbeat_too_fast_ff <= 1'b0;
      miss_cnt_ff <= 1'b0;
    end else begin
      // R4: tone received
      if (i_fault_tone) begin
        fault_rec_ff <= 1'b1;
      end
      // R5: second consecutive miss sets flag; a seen heartbeat restarts the count
      if (i_hb_missed) begin
        if (miss_cnt_ff) begin
          hb_miss_ff <= 1'b1;
        end
        miss_cnt_ff <= 1'b1;
      end else if (i_hb_seen) begin
        miss_cnt_ff <= 1'b0;
      end
      // R6: heartbeat too fast
      if (i_hb_early) begin
        heartbeat_too_fast_ff <= 1'b1;
      end
    end
  end

  // R7: both bits reported raw; software gives missing precedence
  assign tone_flags = {5'h00, fault_rec_ff, hb_miss_ff, heartbeat_too_fast_ff};

  // interrupt events on each newly raised flag
  assign events = {
    i_hb_early & ~heartbeat_too_fast_ff,
    i_hb_missed & miss_cnt_ff & ~hb_miss_ff,
    i_fault_tone & ~fault_rec_ff,
    ot_rise,
    ut_rise,
    ov_rise
  };

  // bus decode: word index from byte address
  assign word_idx = i_avs_address[`PFS_ADDR_W-1:2];
  assign req = i_avs_read | i_avs_write;
  assign wr_take = i_avs_write & (state_ff == ST_ACK);
  assign lane0 = i_avs_byteenable[0];

  pfs_irq u_irq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_events(events),
    .i_clr((wr_take && lane0 && word_idx == `PFS_IDX_IRQ_CLR) ? i_avs_writedata[5:0] : 6'h00),
    .i_en_we(wr_take && lane0 && word_idx == `PFS_IDX_IRQ_EN),
    .i_en_wdata(i_avs_writedata[5:0]),
    .o_status(irq_status),
    .o_enable(irq_enable),
    .o_irq(o_irq)
  );

  // read mux; unmapped and write-only words read zero
  always @* begin
    case (word_idx)
      `PFS_IDX_OV: rd_mux = {24'h000000, ov_flags};
      `PFS_IDX_UT: rd_mux = {24'h000000, ut_flags};
      `PFS_IDX_OT: rd_mux = {24'h000000, ot_flags};
      `PFS_IDX_TONE: rd_mux = {24'h000000, tone_flags};
      `PFS_IDX_IRQ_STAT: rd_mux = {26'h0000000, irq_status};
      `PFS_IDX_IRQ_EN: rd_mux = {26'h0000000, irq_enable};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // one wait cycle lets read data come from a flop
  always @* begin
    case (state_ff)
      ST_IDLE: nxt_state = req ? ST_ACK : ST_IDLE;
      ST_ACK: nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      o_avs_readdata <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE && i_avs_read) begin
        o_avs_readdata <= rd_mux;
      end
    end
  end

  assign o_avs_waitrequest = req & (state_ff != ST_ACK);

endmodule // pfs_bank
`default_nettype wire

// file: rtl/pfs_defines.vh
// register offsets, field positions, reset values and widths for the protector fault bank
`ifndef PFS_DEFINES_VH
`define PFS_DEFINES_VH

// printed register indices; byte address is four times the index
`define PFS_IDX_OV 12'h292
`define PFS_IDX_UT 12'h293
`define PFS_IDX_OT 12'h294
`define PFS_IDX_TONE 12'h295
// interrupt block, chosen indices
`define PFS_IDX_IRQ_STAT 12'h2A0
`define PFS_IDX_IRQ_EN 12'h2A1
`define PFS_IDX_IRQ_CLR 12'h2A2

`define PFS_ADDR_W 14
`define PFS_FLAG_RST 8'h00
`define PFS_CHAN_N 6

// tone register fields
`define PFS_TONE_FAST_BIT 0
`define PFS_TONE_MISS_BIT 1
`define PFS_TONE_REC_BIT 2

// interrupt status fields
`define PFS_EV_OV 0
`define PFS_EV_UT 1
`define PFS_EV_OT 2
`define PFS_EV_REC 3
`define PFS_EV_MISS 4
`define PFS_EV_FAST 5
`define PFS_EV_N 6

`endif

// file: rtl/pfs_flag_reg.v
// one status byte: qualified live flags captured into a flop each cycle
`timescale 1ns/10ps
`default_nettype none
`include "pfs_defines.vh"

module pfs_flag_reg (
  input wire i_clk, // core clock
  input wire i_rst_n, // sync reset, active low
  input wire [5:0] i_raw, // comparator outputs
  input wire [5:0] i_valid, // per-channel qualifier
  input wire i_force, // force all flags to fault
  output wire [7:0] o_flags, // registered flags, reserved bits zero
  output wire o_rise // any flag newly set, one-cycle pulse
);

  reg [5:0] flags_ff;
  wire [5:0] nxt_flags;

  // force wins; a disabled comparator reports no fault
  assign nxt_flags = i_force ? 6'h3F : (i_raw & i_valid);

  // flag capture
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      flags_ff <= 6'h00;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign o_flags = {2'h0, flags_ff};
  assign o_rise = |(nxt_flags & ~flags_ff);

endmodule // pfs_flag_reg
`default_nettype wire

// file: rtl/pfs_irq.v
// sticky event status with enable mask and level interrupt
`timescale 1ns/10ps
`default_nettype none
`include "pfs_defines.vh"

module pfs_irq (
  input wire i_clk, // core clock
  input wire i_rst_n, // sync reset, active low
  input wire [5:0] i_events, // event pulses
  input wire [5:0] i_clr, // write-one-to-clear pulses
  input wire i_en_we, // enable register write
  input wire [5:0] i_en_wdata, // enable write data
  output wire [5:0] o_status, // sticky status
  output wire [5:0] o_enable, // enable register
  output wire o_irq // level interrupt
);

  reg [5:0] status_ff;
  reg [5:0] enable_ff;

  // set wins over clear so an event in the clearing cycle is kept
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      status_ff <= 6'h00;
      enable_ff <= 6'h00;
    end else begin
      status_ff <= (status_ff & ~i_clr) | i_events;
      if (i_en_we) begin
        enable_ff <= i_en_wdata;
      end
    end
  end

  assign o_status = status_ff;
  assign o_enable = enable_ff;
  assign o_irq = |(status_ff & enable_ff);

endmodule // pfs_irq
`default_nettype wire

// file: sim/pfs_bank_checker.sv
// port assertions for the fault status bank
`timescale 1ns/10ps
`default_nettype none
module pfs_bank_checker (
  input wire logic i_clk, // clock
  input wire logic i_rst_n, // reset
  input wire logic [13:0] i_avs_address, // addr
  input wire logic i_avs_read, // rd
  input wire logic i_avs_write, // wr
  input wire logic [31:0] o_avs_readdata, // data
  input wire logic o_avs_waitrequest, // stall
  input wire logic [5:0] i_cell_ov_raw, // ov
  input wire logic [5:0] i_cell_cmp_en, // ov en
  input wire logic [5:0] i_therm_ut_raw, // ut
  input wire logic [5:0] i_therm_ot_raw, // ot
  input wire logic [5:0] i_therm_cmp_en, // t en
  input wire logic i_ut_func_en, // ut fn
  input wire logic i_thermistor_reference_output_en, // ref
  input wire logic o_irq // irq
);
  // qualified flags as the ports should show them
  wire rq = i_avs_read | i_avs_write;
  wire done = i_avs_read & !o_avs_waitrequest;
  wire [11:0] idx = i_avs_address[13:2];
  wire [5:0] ut_q = i_therm_ut_raw & i_therm_cmp_en & {6{i_ut_func_en}} | {6{!i_thermistor_reference_output_en}};
  wire [5:0] ot_q = i_thermistor_reference_output_en ? i_therm_ot_raw & i_therm_cmp_en : 6'h3F;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  a_wait_one: assert property (rq && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("no answer after one wait");
  a_wait_idle: assert property (!rq |-> !o_avs_waitrequest) else $error("stall while idle");
  a_wait_back: assert property (rq && !o_avs_waitrequest ##1 rq |-> o_avs_waitrequest)
    else $error("back to back not stalled");
  a_upper_zero: assert property (done |-> o_avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ov_read: assert property (done && idx == 12'h292
    |-> o_avs_readdata[7:0] == {2'h0, $past(i_cell_ov_raw & i_cell_cmp_en, 2)})
    else $error("overvoltage byte wrong");
  a_ut_read: assert property (done && idx == 12'h293
    |-> o_avs_readdata[7:0] == {2'h0, $past(ut_q, 2)}) else $error("undertemp byte wrong");
  a_ot_read: assert property (done && idx == 12'h294
    |-> o_avs_readdata[7:0] == {2'h0, $past(ot_q, 2)}) else $error("overtemp byte wrong");
  a_unmapped_zero: assert property (done && idx < 12'h292 |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  c_ov_read: cover property (done && idx == 12'h292);
  c_irq: cover property ($rose(o_irq));
  c_back: cover property (rq && !o_avs_waitrequest ##1 rq);
endmodule // pfs_bank_checker
bind pfs_bank pfs_bank_checker i_chk (.i_clk, .i_rst_n, .i_avs_address, .i_avs_read,
  .i_avs_write, .o_avs_readdata, .o_avs_waitrequest, .i_cell_ov_raw, .i_cell_cmp_en,
  .i_therm_ut_raw, .i_therm_ot_raw, .i_therm_cmp_en, .i_ut_func_en, .i_thermistor_reference_output_en, .o_irq);
`default_nettype wire

// file: sim/pfs_bank_tb.sv
// self-checking bench for the fault status bank
`timescale 1ns/10ps
`default_nettype none
module pfs_bank_tb;
  logic i_clk = 1'b0, i_rst_n = 1'b0, rd = 1'b0, wr = 1'b0, ref_en = 1'b1, fn_en = 1'b0;
  logic [13:0] adr = 14'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic wait_s, irq;
  logic [5:0] ov = 6'h0, oven = 6'h0, ut = 6'h0, ot = 6'h0, ten = 6'h0;
  logic [3:0] evs = 4'h0, be = 4'hF;
  logic [15:0] lf = 16'h6FFF;
  logic [7:0] exq[$];
  int error_cnt = 0, checks = 0;
  pfs_bank i_pfs_bank (.i_clk, .i_rst_n, .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wait_s), .i_cell_ov_raw(ov),
    .i_cell_cmp_en(oven), .i_therm_ut_raw(ut), .i_therm_ot_raw(ot), .i_therm_cmp_en(ten),
    .i_ut_func_en(fn_en), .i_thermistor_reference_output_en(ref_en), .i_fault_tone(evs[3]), .i_hb_missed(evs[2]),
    .i_hb_seen(evs[1]), .i_hb_early(evs[0]), .o_irq(irq));
  // 40 MHz clock
  always #12.5 i_clk = ~i_clk;
  function automatic logic [15:0] nxt(input logic [15:0] s);
    for (int i = 0; i < 16; i++) s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    return s;
  endfunction
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // request stays up until waitrequest is seen low; no release so reads can go back to back
  task automatic bus(input logic w, input logic [11:0] idx, input logic [7:0] v);
    if (!w) exq.push_back(v);
    rd <= !w;
    wr <= w;
    adr <= {idx, 2'b00};
    wd <= {24'h0, v};
    do @(posedge i_clk); while (wait_s !== 1'b0);
  endtask
  task automatic idle;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge i_clk);
  endtask
  // one-cycle event pulse: tone, missed, seen, early
  // the bus is released first so a held read cannot complete unobserved and steal a note
  task automatic ev(input logic [3:0] e);
    rd <= 1'b0;
    wr <= 1'b0;
    evs <= e;
    @(posedge i_clk);
    evs <= 4'h0;
    @(posedge i_clk);
  endtask
  // monitor takes the oldest note at each completed read
  always @(posedge i_clk)
    if (rd && wait_s === 1'b0 && exq.size() > 0) cmp(rdata[7:0], exq.pop_front());
  task automatic end_of_test;
    $display("error_cnt %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog cuts a hung handshake short
  initial begin
    #20000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    bus(0, 12'h292, 8'h00);
    bus(0, 12'h295, 8'h00);
    bus(0, 12'h100, 8'h00);
    bus(1, 12'h292, 8'hFF);
    bus(0, 12'h292, 8'h00);
    ev(4'h1);
    bus(0, 12'h295, 8'h01);
    bus(0, 12'h2A0, 8'h20);
    idle;
    cmp({7'h0, irq}, 8'h00);
    bus(1, 12'h2A1, 8'h38);
    bus(0, 12'h2A1, 8'h38);
    // a write with lane zero off must leave the mask alone
    be <= 4'hE;
    bus(1, 12'h2A1, 8'h07);
    be <= 4'hF;
    bus(0, 12'h2A1, 8'h38);
    idle;
    cmp({7'h0, irq}, 8'h01);
    // a heartbeat between two misses keeps the missing flag clear
    ev(4'h4);
    ev(4'h2);
    ev(4'h4);
    bus(0, 12'h295, 8'h01);
    idle;
    ev(4'h4);
    bus(0, 12'h295, 8'h03);
    idle;
    ev(4'h8);
    bus(0, 12'h295, 8'h07);
    bus(0, 12'h2A0, 8'h38);
    bus(1, 12'h2A2, 8'h38);
    bus(0, 12'h2A0, 8'h00);
    idle;
    cmp({7'h0, irq}, 8'h00);
    // forced thermistor flags and one cell fault raise the low three events
    ov <= 6'h01;
    oven <= 6'h01;
    ref_en <= 1'b0;
    idle;
    bus(0, 12'h2A0, 8'h07);
    bus(1, 12'h2A1, 8'h01);
    idle;
    cmp({7'h0, irq}, 8'h01);
    bus(1, 12'h2A2, 8'h07);
    idle;
    cmp({7'h0, irq}, 8'h00);
    // mid-run reset is the only way to drop sticky tone flags; it also clears the mask
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    bus(0, 12'h295, 8'h00);
    bus(0, 12'h2A1, 8'h00);
    idle;
    // random comparator pictures, reference off about a quarter of the time
    repeat (10) begin
      lf = nxt(lf);
      ov <= lf[5:0];
      oven <= lf[11:6];
      ref_en <= lf[12] | lf[13];
      fn_en <= lf[14];
      lf = nxt(lf);
      ut <= lf[5:0];
      ot <= lf[11:6];
      ten <= lf[15:10];
      @(posedge i_clk);
      bus(0, 12'h292, {2'h0, ov & oven});
      bus(0, 12'h293, {2'h0, ut & ten & {6{fn_en}} | {6{!ref_en}}});
      bus(0, 12'h294, {2'h0, ref_en ? ot & ten : 6'h3F});
      idle;
    end
    end_of_test;
  end
endmodule // pfs_bank_tb
`default_nettype wire
